/* File: rtl/rqfc_regs.vh */
`ifndef RQFC_REGS_VH
`define RQFC_REGS_VH
// register addresses
`define RQFC_A_GCR      4'h0
`define RQFC_A_MFCR     4'h1
`define RQFC_A_PTLO     4'h2
`define RQFC_A_PTHI     4'h3
`define RQFC_A_RQSIZE   4'h4
`define RQFC_A_RQHT     4'h5
`define RQFC_A_RQLT     4'h6
`define RQFC_A_TQSIZE   4'h7
`define RQFC_A_TQHT     4'h8
`define RQFC_A_TQLT     4'h9
`define RQFC_A_RQSTAT   4'ha
`define RQFC_A_TQSTAT   4'hb
`define RQFC_A_RQLVL    4'hc
`define RQFC_A_TQLVL    4'hd
// general control bits
`define RQFC_B_AUTO     0
`define RQFC_B_JAM      1
`define RQFC_B_FDX      2
// mac flow control bits
`define RQFC_B_FCE      0
`define RQFC_B_BUSY     1
`define RQFC_B_PRC      2
// latched status bits
`define RQFC_B_HIGH     0
`define RQFC_B_LOW      1
`define RQFC_B_OVFL     2
// reset values
`define RQFC_GCR_RST    8'h01
`define RQFC_MFCR_RST   8'h00
`define RQFC_PT_RST     16'h0000
`define RQFC_SIZE_RST   8'h00
// pause destination, multicast
`define RQFC_PAUSE_DA   48'h0180_6200_0001
// corrupt bytes at frame start, as nibbles
`define RQFC_JAM_BYTES  4
`define RQFC_JAM_NIBS   (2 * `RQFC_JAM_BYTES)
`define RQFC_JAM_NIBBLE 4'h5
// one pause quantum, 512 bit times at 100 Mbps, in ns
`define RQFC_QUANTUM_NS 5120
`define RQFC_CLK_NS     10
`define RQFC_QUANTUM_CYC (`RQFC_QUANTUM_NS / `RQFC_CLK_NS)
`endif

/* File: rtl/rqfc_top.v */
`timescale 1ns/10ps
`include "rqfc_regs.vh"

module rqfc_top (
    input  wire        sys_clk,         // system clock, 100 MHz
    input  wire        nrst,            // async reset, active low
    input  wire [3:0]  reg_addr,        // register address
    input  wire [7:0]  reg_wdata,       // register write data
    input  wire        reg_wr,          // write strobe
    input  wire        reg_rd,          // read strobe
    output reg  [7:0]  reg_rdata,       // read data, cycle after strobe
    input  wire        mac_req,         // mac side transfer request
    input  wire        mac_wr,          // 1 store rx frame, 0 fetch tx
    input  wire        hdlc_req,        // hdlc side transfer request
    input  wire        hdlc_wr,         // 1 store tx frame, 0 fetch rx
    output reg         mac_gnt,         // mac request taken
    output reg         hdlc_gnt,        // hdlc request taken
    output reg         sdram_cmd_valid, // sdram packet command
    output reg         sdram_cmd_wr,    // command stores a packet
    output reg         sdram_cmd_rxq,   // command targets rx queue
    input  wire        mii_rx_clk,      // phy receive clock
    input  wire        mii_rx_dv,       // phy receive data valid
    input  wire [3:0]  mii_rxd,         // phy receive nibble
    output reg         mac_rx_dv,       // nibble valid toward mac
    output reg  [3:0]  mac_rxd,         // nibble toward mac, maybe jammed
    output reg         jam_active,      // current frame is being jammed
    output reg         rx_frame_drop,   // frame end discarded, pulse
    output reg         pause_send,      // send pause frame, pulse
    output reg  [47:0] pause_dest,      // pause destination address
    output reg  [15:0] pause_time,      // timer carried in pause
    input  wire        rx_pause_seen,   // pause frame parsed, pulse
    input  wire [15:0] rx_pause_quanta, // its timer value
    output reg         mac_tx_pause     // transmitter held by far end
);

    // registers
    reg  [7:0]  gcr;                    // general control
    reg  [7:0]  mfcr;                   // mac flow control
    reg  [15:0] ptimer;                 // pause timer value
    reg  [7:0]  rq_size;                // rx size, units of 32
    reg  [7:0]  rq_high;                // rx high threshold
    reg  [7:0]  rq_low;                 // rx low threshold
    reg  [7:0]  tq_size;                // tx size, units of 32
    reg  [7:0]  tq_high;                // tx high threshold
    reg  [7:0]  tq_low;                 // tx low threshold
    reg  [2:0]  rq_stat;                // rx latched status
    reg  [1:0]  tq_stat;                // tx latched status
    reg  [13:0] rq_lvl;                 // rx packets held
    reg  [13:0] tq_lvl;                 // tx packets held
    reg         arb_mac_last;           // mac won last contest
    // link sampling
    reg  [2:0]  clk_s;                  // rx clock sync and history
    reg  [1:0]  dv_s;                   // rx dv synchroniser
    reg  [7:0]  rxd_s;                  // rx data synchroniser
    reg         dv_q;                   // dv at last rx clock edge
    reg  [3:0]  jam_cnt;                // nibbles left to corrupt
    reg  [15:0] hold_cnt;               // received pause quanta left
    reg  [9:0]  quant_cnt;              // cycles within a quantum

    // decoded controls
    wire auto   = gcr[`RQFC_B_AUTO];
    wire fdx    = gcr[`RQFC_B_FDX];
    // sizes and thresholds count in units of 32 packets, so the
    // level compares against the register value shifted by five
    wire [13:0] rq_cap = {1'b0, rq_size, 5'h00};
    wire [13:0] rq_hi  = {1'b0, rq_high, 5'h00};
    wire [13:0] rq_lo  = {1'b0, rq_low, 5'h00};
    wire [13:0] tq_hi  = {1'b0, tq_high, 5'h00};
    wire [13:0] tq_lo  = {1'b0, tq_low, 5'h00};
    wire rq_above = (rq_lvl > rq_hi);   // high threshold state
    wire rq_full  = (rq_lvl >= rq_cap); // no room for a frame
    // a high threshold equal to the size can never be passed, so
    // the host must keep it below the size for flow control
    // constants cut to the counter widths on purpose
    wire [31:0] jam_load  = `RQFC_JAM_NIBS - 1;    // nibbles after first
    wire [31:0] quant_end = `RQFC_QUANTUM_CYC - 1; // last quantum cycle
    // device owns fce and jam in auto mode
    wire fce_eff  = auto ? 1'b1 : mfcr[`RQFC_B_FCE];
    wire jam_eff  = auto ? (~fdx & rq_above)
                         : (gcr[`RQFC_B_JAM] & ~fdx);
    wire wr_gcr   = reg_wr & (reg_addr == `RQFC_A_GCR);
    wire wr_mfcr  = reg_wr & (reg_addr == `RQFC_A_MFCR);
    wire rd_rqst  = reg_rd & (reg_addr == `RQFC_A_RQSTAT);
    wire rd_tqst  = reg_rd & (reg_addr == `RQFC_A_TQSTAT);

    // link edges from sampled clock, frame edges from sampled dv
    wire rx_edge   = clk_s[1] & ~clk_s[2];
    wire frm_start = rx_edge & dv_s[1] & ~dv_q;
    wire frm_end   = rx_edge & ~dv_s[1] & dv_q;

    // arbiter choice: alternate when both sides ask
    // alternation keeps a busy side from starving the other one
    wire pick_mac  = mac_req & (~hdlc_req | ~arb_mac_last);
    wire pick_hdlc = hdlc_req & ~pick_mac;
    wire rq_in     = pick_mac & mac_wr;
    wire rq_out    = pick_hdlc & ~hdlc_wr;
    wire tq_in     = pick_hdlc & hdlc_wr;
    wire tq_out    = pick_mac & ~mac_wr;
    wire rq_take   = rq_in & ~rq_full;
    wire [13:0] next_rq = rq_lvl + {13'h0000, rq_take}
                        - {13'h0000, rq_out & (rq_lvl != 14'h0000)};
    wire [13:0] next_tq = tq_lvl
        + {13'h0000, tq_in & ({1'b0, tq_size, 5'h00} > tq_lvl)}
        - {13'h0000, tq_out & (tq_lvl != 14'h0000)};

    // auto pause request: each frame in high state, full duplex
    wire auto_pause = auto & fdx & rq_above & frm_end;

    // link sampling, two flops before any use
    // the third clock flop is history only, for edge detection
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            clk_s <= 3'h0;
            dv_s  <= 2'h0;
            rxd_s <= 8'h00;
            dv_q  <= 1'b0;
        end else begin
            clk_s <= {clk_s[1:0], mii_rx_clk};
            dv_s  <= {dv_s[0], mii_rx_dv};
            rxd_s <= {rxd_s[3:0], mii_rxd};
            if (rx_edge) begin
                dv_q <= dv_s[1];
            end
        end
    end

    // arbiter grants and queue occupancy
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mac_gnt         <= 1'b0;
            hdlc_gnt        <= 1'b0;
            sdram_cmd_valid <= 1'b0;
            sdram_cmd_wr    <= 1'b0;
            sdram_cmd_rxq   <= 1'b0;
            arb_mac_last    <= 1'b0;
            rq_lvl          <= 14'h0000;
            tq_lvl          <= 14'h0000;
        end else begin
            mac_gnt         <= pick_mac;
            hdlc_gnt        <= pick_hdlc;
            // a store refused for lack of room reaches no sdram
            sdram_cmd_valid <= (pick_mac | pick_hdlc)
                               & ~(rq_in & rq_full);
            sdram_cmd_wr    <= rq_in | tq_in;
            sdram_cmd_rxq   <= rq_in | rq_out;
            if (mac_req & hdlc_req) begin
                arb_mac_last <= pick_mac;
            end
            rq_lvl <= next_rq;
            tq_lvl <= next_tq;
        end
    end

    // latched status, set beats the clearing read
    // so an event in the cycle of the read is seen by the next read
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rq_stat <= 3'h0;
            tq_stat <= 2'h0;
        end else begin
            // rx: high rising, low falling, overflow
            rq_stat[`RQFC_B_HIGH] <= (rq_stat[`RQFC_B_HIGH] & ~rd_rqst)
                | (next_rq > rq_hi && !rq_above);
            rq_stat[`RQFC_B_LOW]  <= (rq_stat[`RQFC_B_LOW] & ~rd_rqst)
                | (next_rq < rq_lo && rq_lvl >= rq_lo);
            rq_stat[`RQFC_B_OVFL] <= (rq_stat[`RQFC_B_OVFL] & ~rd_rqst)
                | (rq_in & rq_full)
                | (frm_end & rq_full);
            // tx thresholds only flag, nothing stalls
            tq_stat[`RQFC_B_HIGH] <= (tq_stat[`RQFC_B_HIGH] & ~rd_tqst)
                | (next_tq > tq_hi && tq_lvl <= tq_hi);
            tq_stat[`RQFC_B_LOW]  <= (tq_stat[`RQFC_B_LOW] & ~rd_tqst)
                | (next_tq < tq_lo && tq_lvl >= tq_lo);
        end
    end

    // host registers; auto mode keeps fce and busy for itself
    // fce written in auto mode is dropped, so leaving auto mode
    // falls back to the value last written in manual mode
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gcr     <= `RQFC_GCR_RST;
            mfcr    <= `RQFC_MFCR_RST;
            ptimer  <= `RQFC_PT_RST;
            rq_size <= `RQFC_SIZE_RST;
            rq_high <= `RQFC_SIZE_RST;
            rq_low  <= `RQFC_SIZE_RST;
            tq_size <= `RQFC_SIZE_RST;
            tq_high <= `RQFC_SIZE_RST;
            tq_low  <= `RQFC_SIZE_RST;
        end else begin
            if (wr_gcr) begin
                gcr <= {5'h00, reg_wdata[2:0]};
            end
            // response control always host owned
            if (wr_mfcr) begin
                mfcr[`RQFC_B_PRC] <= reg_wdata[`RQFC_B_PRC];
            end
            if (wr_mfcr && !auto) begin
                mfcr[`RQFC_B_FCE] <= reg_wdata[`RQFC_B_FCE];
            end
            // busy: set by host in manual or by device in auto,
            // self clears on the next cycle, whether or not a pause request is issued
            if (auto_pause || (wr_mfcr && !auto
                               && reg_wdata[`RQFC_B_BUSY])) begin
                mfcr[`RQFC_B_BUSY] <= 1'b1;
            end else if (mfcr[`RQFC_B_BUSY]) begin
                mfcr[`RQFC_B_BUSY] <= 1'b0;
            end
            if (reg_wr) begin
                case (reg_addr)
                    `RQFC_A_PTLO:   ptimer[7:0]  <= reg_wdata;
                    `RQFC_A_PTHI:   ptimer[15:8] <= reg_wdata;
                    `RQFC_A_RQSIZE: rq_size      <= reg_wdata;
                    `RQFC_A_RQHT:   rq_high      <= reg_wdata;
                    `RQFC_A_RQLT:   rq_low       <= reg_wdata;
                    `RQFC_A_TQSIZE: tq_size      <= reg_wdata;
                    `RQFC_A_TQHT:   tq_high      <= reg_wdata;
                    `RQFC_A_TQLT:   tq_low       <= reg_wdata;
                    default:        ;
                endcase
            end
        end
    end

    // read data, one cycle after the strobe, else zero
    // a status read returns the latches as they were before clearing
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `RQFC_A_GCR:    reg_rdata <= {5'h00, fdx, jam_eff, auto};
                `RQFC_A_MFCR:   reg_rdata <= {5'h00, mfcr[2:1], fce_eff};
                `RQFC_A_PTLO:   reg_rdata <= ptimer[7:0];
                `RQFC_A_PTHI:   reg_rdata <= ptimer[15:8];
                `RQFC_A_RQSIZE: reg_rdata <= rq_size;
                `RQFC_A_RQHT:   reg_rdata <= rq_high;
                `RQFC_A_RQLT:   reg_rdata <= rq_low;
                `RQFC_A_TQSIZE: reg_rdata <= tq_size;
                `RQFC_A_TQHT:   reg_rdata <= tq_high;
                `RQFC_A_TQLT:   reg_rdata <= tq_low;
                `RQFC_A_RQSTAT: reg_rdata <= {5'h00, rq_stat};
                `RQFC_A_TQSTAT: reg_rdata <= {6'h00, tq_stat};
                `RQFC_A_RQLVL:  reg_rdata <= rq_lvl[12:5];
                `RQFC_A_TQLVL:  reg_rdata <= tq_lvl[12:5];
                default:        reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // receive path with jam of the first bytes of a new frame
    // jam_active stands exactly while the replaced nibbles stand;
    // data and valid move together so the mac sees whole nibbles
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            jam_cnt       <= 4'h0;
            jam_active    <= 1'b0;
            mac_rx_dv     <= 1'b0;
            mac_rxd       <= 4'h0;
            rx_frame_drop <= 1'b0;
        end else begin
            rx_frame_drop <= frm_end & rq_full;
            if (rx_edge) begin
                mac_rx_dv <= dv_s[1];
                // arming is decided only at a frame start, so
                // the frame crossing the threshold passes intact
                if (frm_start && jam_eff && fce_eff) begin
                    jam_cnt    <= jam_load[3:0];
                    jam_active <= 1'b1;
                    mac_rxd    <= `RQFC_JAM_NIBBLE;
                end else if (jam_cnt != 4'h0 && dv_s[1]) begin
                    jam_cnt    <= jam_cnt - 4'h1;
                    mac_rxd    <= `RQFC_JAM_NIBBLE;
                end else begin
                    jam_active <= 1'b0;
                    jam_cnt    <= 4'h0;
                    mac_rxd    <= rxd_s[7:4];
                end
            end
        end
    end

    // pause generation and obeying pause from the far end
    // a new pause from the far end restarts the hold at its value,
    // and the quantum counter restarts so every quantum is whole
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pause_send   <= 1'b0;
            pause_dest   <= `RQFC_PAUSE_DA;
            pause_time   <= `RQFC_PT_RST;
            hold_cnt     <= 16'h0000;
            quant_cnt    <= 10'h000;
            mac_tx_pause <= 1'b0;
        end else begin
            pause_dest <= `RQFC_PAUSE_DA;
            // busy bit issues exactly one request, full duplex with fce set
            pause_send <= mfcr[`RQFC_B_BUSY] & fce_eff & fdx;
            pause_time <= ptimer;
            if (rx_pause_seen && mfcr[`RQFC_B_PRC]) begin
                hold_cnt  <= rx_pause_quanta;
                quant_cnt <= 10'h000;
            end else if (hold_cnt != 16'h0000) begin
                if (quant_cnt == quant_end[9:0]) begin
                    quant_cnt <= 10'h000;
                    hold_cnt  <= hold_cnt - 16'h0001;
                end else begin
                    quant_cnt <= quant_cnt + 10'h001;
                end
            end
            mac_tx_pause <= (hold_cnt != 16'h0000);
        end
    end

endmodule // rqfc_top

/* File: verif/rqfc_assertions.sv */
`timescale 1ns/10ps
`include "rqfc_regs.vh"
// port relations of the queue arbiter and the flow control logic
module rqfc_checker (
    input logic        sys_clk,
    input logic        nrst,
    input logic [3:0]  reg_addr,
    input logic [7:0]  reg_wdata,
    input logic        reg_wr,
    input logic        mac_req,
    input logic        mac_wr,
    input logic        hdlc_wr,
    input logic        mac_gnt,
    input logic        hdlc_gnt,
    input logic        sdram_cmd_valid,
    input logic        sdram_cmd_wr,
    input logic        sdram_cmd_rxq,
    input logic        mac_rx_dv,
    input logic [3:0]  mac_rxd,
    input logic        jam_active,
    input logic        pause_send,
    input logic [47:0] pause_dest,
    input logic        rx_pause_seen,
    input logic [15:0] rx_pause_quanta,
    input logic        mac_tx_pause
);
    logic auto_q; // automatic mode as last written
    logic fdx_q;  // full duplex as last written
    logic prc_q;  // obey received pause as last written
    // mirror of the mode bits, followed from host writes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            auto_q <= 1'b1;
            fdx_q  <= 1'b0;
            prc_q  <= 1'b0;
        end else if (reg_wr && reg_addr == `RQFC_A_GCR) begin
            auto_q <= reg_wdata[`RQFC_B_AUTO];
            fdx_q  <= reg_wdata[`RQFC_B_FDX];
        end else if (reg_wr && reg_addr == `RQFC_A_MFCR) begin
            prc_q  <= reg_wdata[`RQFC_B_PRC];
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // host asks for a pause by hand, then the request leaves
    sequence s_busy_wr;
        reg_wr && reg_addr == `RQFC_A_MFCR && reg_wdata[1:0] == 2'b11
            && !auto_q && fdx_q;
    endsequence
    sequence s_pause_out;
        ##[1:2] pause_send;
    endsequence
    chk_gnt_exclusive: assert property (!(mac_gnt && hdlc_gnt))
        else $error("two grants in one cycle");
    chk_gnt_cause: assert property (mac_gnt |-> $past(mac_req))
        else $error("mac grant without request");
    chk_cmd_grant: assert property (
        sdram_cmd_valid |-> mac_gnt || hdlc_gnt)
        else $error("sdram command without grant");
    chk_cmd_mac_route: assert property (
        mac_gnt |-> sdram_cmd_wr == $past(mac_wr)
            && sdram_cmd_rxq == $past(mac_wr))
        else $error("mac command routed to wrong queue");
    chk_cmd_hdlc_route: assert property (
        hdlc_gnt |-> sdram_cmd_wr == $past(hdlc_wr)
            && sdram_cmd_rxq == !$past(hdlc_wr))
        else $error("hdlc command routed to wrong queue");
    chk_pause_dest: assert property (
        pause_send |-> pause_dest == 48'h0180_6200_0001)
        else $error("pause destination wrong");
    chk_pause_pulse: assert property (pause_send |=> !pause_send)
        else $error("pause request longer than one cycle");
    chk_jam_nibble: assert property (
        jam_active && mac_rx_dv |-> mac_rxd == 4'h5)
        else $error("jammed nibble not replaced");
    chk_half_no_pause: assert property (
        auto_q && !fdx_q |-> !pause_send)
        else $error("pause in half duplex");
    chk_full_no_jam: assert property (fdx_q |-> !jam_active)
        else $error("jam in full duplex");
    chk_manual_pause: assert property (s_busy_wr |-> s_pause_out)
        else $error("manual pause request not sent");
    chk_obey_pause: assert property (
        rx_pause_seen && prc_q && rx_pause_quanta != 16'h0000
            |-> ##[1:2] mac_tx_pause)
        else $error("received pause not obeyed");
    chk_ignore_pause: assert property (
        rx_pause_seen && !prc_q && !mac_tx_pause |=> !mac_tx_pause)
        else $error("received pause obeyed while disabled");
endmodule // rqfc_checker

/* File: verif/rqfc_phy_model.sv */
`timescale 1ns/10ps
// phy receive side; its clock runs only during a frame and for two idle cycles after it
module rqfc_phy_model (
    output logic       mii_rx_clk, // receive clock, 80 ns period
    output logic       mii_rx_dv,  // frame valid
    output logic [3:0] mii_rxd     // receive nibble
);
    initial begin
        mii_rx_clk = 1'b0;
        mii_rx_dv  = 1'b0;
        mii_rxd    = 4'h0;
    end
    // idle data never holds still, so stale values cannot pass
    always #37 if (!mii_rx_dv) mii_rxd = ~mii_rxd;
    // one frame of n nibbles, data moves on the falling clock edge
    task automatic send(input int n);
        for (int i = 0; i < n + 2; i++) begin
            #40 mii_rx_clk = 1'b0;
            mii_rx_dv = (i < n);
            mii_rxd   = (i < n) ? 4'ha : ~mii_rxd;
            #40 mii_rx_clk = 1'b1;
        end
        #40 mii_rx_clk = 1'b0;
    endtask
endmodule // rqfc_phy_model

/* File: verif/rx_queue_flow_control_test.sv */
`timescale 1ns/10ps
`include "rqfc_regs.vh"
// bench: register calls, queue traffic and phy frames
module rx_queue_flow_control_test;
    logic        sys_clk = 1'b0;           // system clock
    logic        nrst = 1'b0;              // reset, active low
    logic [3:0]  reg_addr = 4'h0;          // register index
    logic [7:0]  reg_wdata = 8'h00;        // write data
    logic        reg_wr = 1'b0;            // write strobe
    logic        reg_rd = 1'b0;            // read strobe
    logic        mac_req = 1'b0;           // mac request
    logic        mac_wr = 1'b0;            // mac direction
    logic        hdlc_req = 1'b0;          // hdlc request
    logic        hdlc_wr = 1'b0;           // hdlc direction
    logic        rx_pause_seen = 1'b0;     // pause frame parsed
    logic [15:0] rx_pause_quanta = 16'h0;  // its timer
    logic [7:0]  reg_rdata, v;             // read data, last read
    logic        mac_gnt, hdlc_gnt, sdram_cmd_valid, sdram_cmd_wr;
    logic        sdram_cmd_rxq, mii_rx_clk, mii_rx_dv, mac_rx_dv;
    logic        jam_active, rx_frame_drop, pause_send, mac_tx_pause;
    logic [3:0]  mii_rxd, mac_rxd;         // phy and mac nibbles
    logic [47:0] pause_dest;               // pause destination
    logic [15:0] pause_time;               // pause timer sent
    int miscompares, num_checks;           // check tallies
    int mg, hg, sends, drops, jam5, refused; // event tallies
    always #5 sys_clk = ~sys_clk;
    rqfc_top DUT (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .mac_req, .mac_wr, .hdlc_req, .hdlc_wr,
        .mac_gnt, .hdlc_gnt, .sdram_cmd_valid, .sdram_cmd_wr,
        .sdram_cmd_rxq, .mii_rx_clk, .mii_rx_dv, .mii_rxd, .mac_rx_dv,
        .mac_rxd, .jam_active, .rx_frame_drop, .pause_send, .pause_dest,
        .pause_time, .rx_pause_seen, .rx_pause_quanta, .mac_tx_pause);
    rqfc_phy_model u_phy (.mii_rx_clk, .mii_rx_dv, .mii_rxd);
    // tallies event outputs between edges, where they are settled
    always @(negedge sys_clk) begin
        mg      += (mac_gnt === 1'b1);
        hg      += (hdlc_gnt === 1'b1);
        sends   += (pause_send === 1'b1);
        drops   += (rx_frame_drop === 1'b1);
        jam5    += (mac_rx_dv === 1'b1 && mac_rxd === 4'h5);
        refused += (mac_gnt === 1'b1 && sdram_cmd_valid === 1'b0);
    end
    task automatic check(input string what, input logic [47:0] exp,
                         input logic [47:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        @(posedge sys_clk);
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1 v = reg_rdata;
        @(posedge sys_clk);
    endtask
    // requests held for n edges, one pick per edge
    task automatic xfer(input logic mq, hq, mw, hw, input int n);
        mac_req  <= mq;
        hdlc_req <= hq;
        mac_wr   <= mw;
        hdlc_wr  <= hw;
        repeat (n) @(posedge sys_clk);
        mac_req  <= 1'b0;
        hdlc_req <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic frame(input int n);
        u_phy.send(n);
        repeat (12) @(posedge sys_clk);
    endtask
    task automatic pause_in(input logic [15:0] q);
        rx_pause_seen   <= 1'b1;
        rx_pause_quanta <= q;
        @(posedge sys_clk);
        rx_pause_seen   <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // watchdog: the sequence needs well under 10k cycles
    initial begin
        #200000;
        miscompares++;
        $display("Error watchdog expected finish seen timeout");
        stop_test;
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        rd(`RQFC_A_GCR); check("gcr reset", 8'h01, v);
        wr(`RQFC_A_GCR, 8'h05);
        wr(`RQFC_A_MFCR, 8'h03);
        rd(`RQFC_A_MFCR); check("mfcr auto", 8'h01, v);
        check("auto busy write", 0, sends);
        rd(4'hf); check("unmapped", 8'h00, v);
        wr(`RQFC_A_PTLO, 8'h50);
        wr(`RQFC_A_PTHI, 8'h00);
        wr(`RQFC_A_RQSIZE, 8'h02);
        wr(`RQFC_A_RQHT, 8'h01);
        wr(`RQFC_A_GCR, 8'h05);
        xfer(1, 0, 1, 0, 33);
        check("rx stores", 33, mg);
        rd(`RQFC_A_RQLVL); check("rx level", 8'h01, v);
        rd(`RQFC_A_RQSTAT); check("high latch", 8'h01, v);
        rd(`RQFC_A_RQSTAT); check("latch cleared", 8'h00, v);
        frame(16);
        frame(16);
        check("pause per frame", 2, sends);
        check("pause timer", 16'h0050, pause_time);
        check("pause dest", 48'h0180_6200_0001, pause_dest);
        wr(`RQFC_A_GCR, 8'h01);
        sends = 0;
        jam5 = 0;
        frame(24);
        check("half pause", 0, sends);
        check("jam span", 1, jam5 >= 60 && jam5 <= 68);
        xfer(0, 1, 0, 0, 1);
        jam5 = 0;
        frame(24);
        check("jam below high", 0, jam5);
        fork
            u_phy.send(24);
            begin
                repeat (20) @(posedge sys_clk);
                xfer(1, 0, 1, 0, 1);
            end
        join
        repeat (12) @(posedge sys_clk);
        check("crossing frame", 0, jam5);
        frame(24);
        check("next frame", 1, jam5 >= 60 && jam5 <= 68);
        wr(`RQFC_A_GCR, 8'h04);
        rd(`RQFC_A_MFCR); check("fce kept", 8'h00, v);
        sends = 0;
        wr(`RQFC_A_MFCR, 8'h03);
        repeat (3) @(posedge sys_clk);
        check("manual pause", 1, sends);
        rd(`RQFC_A_MFCR); check("busy done", 8'h01, v);
        wr(`RQFC_A_GCR, 8'h02);
        jam5 = 0;
        frame(24);
        check("manual jam", 1, jam5 >= 60 && jam5 <= 68);
        wr(`RQFC_A_GCR, 8'h04);
        wr(`RQFC_A_MFCR, 8'h04);
        pause_in(16'h0001);
        check("obey pause", 1'b1, mac_tx_pause);
        repeat (520) @(posedge sys_clk);
        check("pause expired", 1'b0, mac_tx_pause);
        wr(`RQFC_A_MFCR, 8'h00);
        pause_in(16'h0001);
        check("ignore pause", 1'b0, mac_tx_pause);
        mg = 0;
        hg = 0;
        xfer(1, 1, 0, 1, 4);
        check("mac share", 2, mg);
        check("hdlc share", 2, hg);
        xfer(1, 0, 1, 0, 31);
        check("full no refusal", 0, refused);
        xfer(1, 0, 1, 0, 1);
        check("store refused", 1, refused);
        frame(16);
        check("frame dropped", 1, drops);
        rd(`RQFC_A_RQSTAT); check("overflow", 1'b1, v[2]);
        wr(`RQFC_A_RQSIZE, 8'h08);
        wr(`RQFC_A_RQHT, 8'h05);
        wr(`RQFC_A_RQLT, 8'h02);
        xfer(0, 1, 0, 0, 1);
        rd(`RQFC_A_RQSTAT); check("low latch", 8'h02, v);
        wr(`RQFC_A_TQSIZE, 8'h02);
        xfer(0, 1, 0, 1, 2);
        rd(`RQFC_A_TQSTAT); check("tx high", 8'h01, v);
        stop_test;
    end
endmodule // rx_queue_flow_control_test

bind rqfc_top rqfc_checker u_chk (.sys_clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .mac_req, .mac_gnt, .hdlc_gnt, .sdram_cmd_valid, .mac_rx_dv,
    .mac_rxd, .jam_active, .pause_send, .pause_dest, .rx_pause_seen,
    .rx_pause_quanta, .mac_tx_pause, .mac_wr, .hdlc_wr, .sdram_cmd_wr,
    .sdram_cmd_rxq);
